// File: src/otp_sec_pkg.sv
// package: constants and types for the tile otp security block
//----------------------------------------------------------------
// Overview of operation
// - security bit 0 shuts jtag out of tile state and memory
// - security bit 1 denies other tiles switch access to processor state
// - security bit 5 forces boot from otp address 0, bypassing boot rom
// - security bit 7 turns on the otp redundant rows
// - bits 8 to 11 each block programming of sectors 0 to 3
// - bit 12 blocks all programming, sectors and security row alike
// - bit 13 blocks jtag reads and writes of this otp
// - bit 14 disables the debug synchronisation pin entirely
// - bits 21 to 15 are a software field without hardware effect
// - bits 31 to 22 extend the jtag user identification code
// - security register loads from otp before protections apply
// - otp is four sectors of 512 rows, 32 bits each
// - programming address comes through 16-bit port 0x100200
// - write data comes through 32-bit port 0x200100
// - programming control goes through 16-bit port 0x100300
// - remaining otp contents copy to sram and run before other code
// - usercode user id comes from bits 22 to 31, zero unprogrammed
// - secure boot image is read from otp row 0
//----------------------------------------------------------------
package otp_sec_pkg;

	// security register fields
	localparam int SEC_JTAG_OFF = 0;
	localparam int SEC_LINK_OFF = 1;
	localparam int SEC_BOOT     = 5;
	localparam int SEC_REDUN    = 7;
	localparam int SEC_LOCK_LO  = 8;
	localparam int SEC_MASTER   = 12;
	localparam int SEC_JTAG_OTP = 13;
	localparam int SEC_DEBUG    = 14;
	localparam int SEC_SW_LO    = 15;
	localparam int SEC_SW_HI    = 21;
	localparam int SEC_UID_LO   = 22;
	localparam int SEC_UID_HI   = 31;
	localparam logic [31:0] SEC_VALID_MASK = 32'hFFFF_FFA3;
	localparam logic [31:0] SEC_RESET      = 32'h0000_0000;

	// otp geometry
	localparam int ROW_W         = 32;
	localparam int SECTORS       = 4;
	localparam int ROWS_PER_SECT = 512;
	localparam int ROWS          = SECTORS * ROWS_PER_SECT;
	localparam int ROW_AW        = 11;
	localparam int SECT_AW       = 2;
	localparam int UID_W         = SEC_UID_HI - SEC_UID_LO + 1;
	localparam logic [ROW_AW-1:0] BOOT_ROW = 11'h000;
	localparam logic [ROW_AW-1:0] LAST_ROW = 11'h7FF;
	localparam logic [ROW_AW-1:0] ROW_STEP = 11'h001;

	// programming ports
	localparam int PORT_W = 16;
	localparam logic [23:0] ADDR_PORT_ID = 24'h100200;
	localparam logic [23:0] DATA_PORT_ID = 24'h200100;
	localparam logic [23:0] CTRL_PORT_ID = 24'h100300;
	localparam int CTL_PROG    = 0;
	localparam int CTL_READ    = 1;
	localparam int CTL_SECROW  = 2;
	localparam int CTL_CLRBLK  = 3;
	localparam int CTL_BUSY    = 8;
	localparam int CTL_BLOCKED = 9;

	// apb map
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] OFS_ADDR   = 8'h00;
	localparam logic [APB_AW-1:0] OFS_DATA   = 8'h04;
	localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h08;
	localparam logic [APB_AW-1:0] OFS_SEC    = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_RDATA  = 8'h10;
	localparam logic [APB_AW-1:0] OFS_ID_ADR = 8'h14;
	localparam logic [APB_AW-1:0] OFS_ID_DAT = 8'h18;
	localparam logic [APB_AW-1:0] OFS_ID_CTL = 8'h1C;

	typedef enum logic [1:0]
	{
		ST_LOAD = 2'b00,
		ST_WAIT = 2'b01,
		ST_COPY = 2'b10,
		ST_RUN  = 2'b11
	} boot_state_type;

endpackage : otp_sec_pkg

// File: src/otp_array.sv
// fuse array: data rows plus the security row, bit-set programming
`timescale 1ns/1ps
`default_nettype none
module otp_array
(
	// clock
	input  wire logic                           ref_clk,
	// programming
	input  wire logic                           progEn,
	input  wire logic                           progSec,
	input  wire logic [otp_sec_pkg::ROW_AW-1:0] progAddr,
	input  wire logic [otp_sec_pkg::ROW_W-1:0]  progData,
	// read
	input  wire logic [otp_sec_pkg::ROW_AW-1:0] rdAddr,
	output var  logic [otp_sec_pkg::ROW_W-1:0]  rdData,
	output var  logic [otp_sec_pkg::ROW_W-1:0]  secWord
);

	// unblown fuses read zero; contents survive reset
	logic [otp_sec_pkg::ROW_W-1:0] rowMem [otp_sec_pkg::ROWS] =
		'{default: '0};
	logic [otp_sec_pkg::ROW_W-1:0] secRow = '0;

	//------------------------------------------------
	// programming: a fuse can only go from 0 to 1
	//------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (progEn && !progSec)
			rowMem[progAddr] <= rowMem[progAddr] | progData;
		if (progEn && progSec)
			secRow <= secRow | progData;
	end

	//------------------------------------------------
	// registered read ports
	//------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		rdData  <= rowMem[rdAddr];
		secWord <= secRow;
	end

endmodule : otp_array
`default_nettype wire

// File: src/otp_security_control.sv
// tile otp with security register, boot copy and apb programming
`timescale 1ns/1ps
`default_nettype none
module otp_security_control
(
	// clock and reset
	input  wire logic                           ref_clk,
	input  wire logic                           rst,
	// apb slave
	input  wire logic [otp_sec_pkg::APB_AW-1:0] paddr,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [31:0]                    pwdata,
	output var  logic [31:0]                    prdata,
	output var  logic                           pready,
	output var  logic                           pslverr,
	// jtag access to the otp
	input  wire logic                           jtagOtpReq,
	input  wire logic                           jtagOtpWrite,
	input  wire logic [otp_sec_pkg::PORT_W-1:0] jtagOtpAddr,
	input  wire logic [31:0]                    jtagOtpWdata,
	output var  logic                           jtagOtpAck,
	output var  logic                           jtagOtpDenied,
	output var  logic [31:0]                    jtagOtpRdata,
	// protection outputs
	output var  logic                           jtagTapEnable,
	output var  logic                           linkAccessEnable,
	output var  logic                           redundantRowsEn,
	output var  logic [otp_sec_pkg::UID_W-1:0]  userIdentExtension,
	// debug pin
	input  wire logic                           debugPinIn,
	input  wire logic                           debugBreak,
	output var  logic                           debugPinOut,
	output var  logic                           debugPinOeN,
	output var  logic                           debugRequest,
	// boot copy to sram
	output var  logic                           sramWrValid,
	output var  logic [otp_sec_pkg::ROW_AW-1:0] sramWrAddr,
	output var  logic [31:0]                    sramWrData,
	output var  logic                           bootFromOtp,
	output var  logic                           coreRelease
);

	otp_sec_pkg::boot_state_type state_reg;

	logic [31:0]                    secReg_reg;
	logic [otp_sec_pkg::PORT_W-1:0] otpAddr_reg;
	logic [31:0]                    otpData_reg;
	logic [31:0]                    readData_reg;
	logic                           blocked_reg;
	logic                           rdPend_reg;
	logic                           jtagRdPend_reg;
	logic [otp_sec_pkg::ROW_AW-1:0] copyIdx_reg;
	logic                           progEn_reg;
	logic                           progSec_reg;
	logic [otp_sec_pkg::ROW_AW-1:0] progAddr_reg;
	logic [31:0]                    progData_reg;
	logic                           dbgSync1_reg;
	logic                           dbgSync2_reg;
	logic [otp_sec_pkg::ROW_AW-1:0] rdAddr;
	logic [31:0]                    secWord;
	logic [otp_sec_pkg::SECTORS-1:0] lockVec;
	logic [31:0]                    rdMux;
	logic [31:0]                    ctrlRd;
	logic                           mapped;
	logic                           running;
	logic                           secLoaded;
	logic                           apbFirst;
	logic                           apbWrite;
	logic                           ctrlWrite;
	logic                           apbOp;
	logic                           jtagIssue;
	logic                           jtagBlocked;
	logic                           apbProgBlk;
	logic                           jtagProgBlk;

	//------------------------------------------------
	// decode helpers
	//------------------------------------------------
	function automatic logic regHit(
		input logic [otp_sec_pkg::APB_AW-1:0] a,
		input logic [otp_sec_pkg::APB_AW-1:0] ofs);
		regHit = (a == ofs);
	endfunction : regHit

	// master lock, sector lock, or a row past the array
	function automatic logic progBlocked(
		input logic [31:0]                     sec,
		input logic [otp_sec_pkg::SECTORS-1:0] lock,
		input logic                            toSec,
		input logic [otp_sec_pkg::PORT_W-1:0]  a);
		logic outside;
		outside = (a[otp_sec_pkg::PORT_W-1:otp_sec_pkg::ROW_AW] != '0);
		progBlocked = sec[otp_sec_pkg::SEC_MASTER]
			| (!toSec & (outside
			| lock[a[otp_sec_pkg::ROW_AW-1 -: otp_sec_pkg::SECT_AW]]));
	endfunction : progBlocked

	genvar gi;
	generate
		for (gi = 0; gi < otp_sec_pkg::SECTORS; gi++)
		begin : g_lock
			assign lockVec[gi] = secReg_reg[otp_sec_pkg::SEC_LOCK_LO + gi];
		end
	endgenerate

	assign running   = (state_reg == otp_sec_pkg::ST_RUN);
	assign secLoaded = running || (state_reg == otp_sec_pkg::ST_COPY);
	assign apbFirst  = psel && penable && !pready;
	assign apbWrite  = psel && penable && pready && pwrite;
	assign ctrlWrite = apbWrite && regHit(paddr, otp_sec_pkg::OFS_CTRL);
	assign apbOp     = running && ctrlWrite
		&& (pwdata[otp_sec_pkg::CTL_PROG] || pwdata[otp_sec_pkg::CTL_READ]);
	// apb commands win; jtag simply waits a cycle
	assign jtagIssue = running && jtagOtpReq && !jtagOtpAck
		&& !jtagRdPend_reg && !apbOp;
	assign jtagBlocked = secReg_reg[otp_sec_pkg::SEC_JTAG_OFF]
		| secReg_reg[otp_sec_pkg::SEC_JTAG_OTP];
	assign apbProgBlk = apbOp && pwdata[otp_sec_pkg::CTL_PROG]
		&& progBlocked(secReg_reg, lockVec,
		pwdata[otp_sec_pkg::CTL_SECROW], otpAddr_reg);
	assign jtagProgBlk = jtagIssue && jtagOtpWrite && !jtagBlocked
		&& progBlocked(secReg_reg, lockVec, 1'b0, jtagOtpAddr);

	always_comb
	begin
		if (!running)
			rdAddr = copyIdx_reg;
		else if (jtagIssue)
			rdAddr = jtagOtpAddr[otp_sec_pkg::ROW_AW-1:0];
		else
			rdAddr = otpAddr_reg[otp_sec_pkg::ROW_AW-1:0];
	end

	otp_array u_array
	(
		.ref_clk  (ref_clk),
		.progEn   (progEn_reg),
		.progSec  (progSec_reg),
		.progAddr (progAddr_reg),
		.progData (progData_reg),
		.rdAddr   (rdAddr),
		.rdData   (sramWrData),
		.secWord  (secWord)
	);

	//------------------------------------------------
	// power-up load and boot copy
	//------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg   <= otp_sec_pkg::ST_LOAD;
			secReg_reg  <= otp_sec_pkg::SEC_RESET;
			copyIdx_reg <= otp_sec_pkg::BOOT_ROW;
		end
		else
		begin
			case (state_reg)
				otp_sec_pkg::ST_LOAD:
					state_reg <= otp_sec_pkg::ST_WAIT;
				otp_sec_pkg::ST_WAIT:
				begin
					secReg_reg  <= secWord & otp_sec_pkg::SEC_VALID_MASK;
					copyIdx_reg <= otp_sec_pkg::BOOT_ROW;
					state_reg   <= otp_sec_pkg::ST_COPY;
				end
				otp_sec_pkg::ST_COPY:
				begin
					copyIdx_reg <= copyIdx_reg + otp_sec_pkg::ROW_STEP;
					if (copyIdx_reg == otp_sec_pkg::LAST_ROW)
						state_reg <= otp_sec_pkg::ST_RUN;
				end
				otp_sec_pkg::ST_RUN:
					state_reg <= otp_sec_pkg::ST_RUN;
				default:
					state_reg <= otp_sec_pkg::ST_LOAD;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sramWrValid <= 1'b0;
			sramWrAddr  <= otp_sec_pkg::BOOT_ROW;
			coreRelease <= 1'b0;
		end
		else
		begin
			sramWrValid <= (state_reg == otp_sec_pkg::ST_COPY);
			sramWrAddr  <= copyIdx_reg;
			coreRelease <= running;
		end
	end

	//------------------------------------------------
	// protection outputs, quiet until the load is done
	//------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			jtagTapEnable      <= 1'b0;
			linkAccessEnable   <= 1'b0;
			bootFromOtp        <= 1'b0;
			redundantRowsEn    <= 1'b0;
			userIdentExtension <= '0;
		end
		else
		begin
			jtagTapEnable    <= secLoaded
				&& !secReg_reg[otp_sec_pkg::SEC_JTAG_OFF];
			linkAccessEnable <= secLoaded
				&& !secReg_reg[otp_sec_pkg::SEC_LINK_OFF];
			bootFromOtp      <= secLoaded
				&& secReg_reg[otp_sec_pkg::SEC_BOOT];
			redundantRowsEn  <= secLoaded
				&& secReg_reg[otp_sec_pkg::SEC_REDUN];
			userIdentExtension <= secReg_reg[otp_sec_pkg::SEC_UID_HI:
				otp_sec_pkg::SEC_UID_LO];
		end
	end

	//------------------------------------------------
	// debug pin: active low, open drain
	//------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			dbgSync1_reg <= 1'b1;
			dbgSync2_reg <= 1'b1;
			debugRequest <= 1'b0;
			debugPinOeN  <= 1'b1;
			debugPinOut  <= 1'b0;
		end
		else
		begin
			dbgSync1_reg <= debugPinIn;
			dbgSync2_reg <= dbgSync1_reg;
			debugRequest <= secLoaded && !secReg_reg[otp_sec_pkg::SEC_DEBUG]
				&& !dbgSync2_reg;
			debugPinOeN  <= !(secLoaded && debugBreak
				&& !secReg_reg[otp_sec_pkg::SEC_DEBUG]);
			debugPinOut  <= 1'b0;
		end
	end

	//------------------------------------------------
	// programming and reads through the three ports
	//------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			progEn_reg   <= 1'b0;
			progSec_reg  <= 1'b0;
			progAddr_reg <= otp_sec_pkg::BOOT_ROW;
			progData_reg <= '0;
		end
		else
		begin
			progEn_reg <= 1'b0;
			if (apbOp && pwdata[otp_sec_pkg::CTL_PROG])
			begin
				progEn_reg   <= !apbProgBlk;
				progSec_reg  <= pwdata[otp_sec_pkg::CTL_SECROW];
				progAddr_reg <= otpAddr_reg[otp_sec_pkg::ROW_AW-1:0];
				progData_reg <= otpData_reg;
			end
			else if (jtagIssue && jtagOtpWrite && !jtagBlocked)
			begin
				progEn_reg   <= !jtagProgBlk;
				progSec_reg  <= 1'b0;
				progAddr_reg <= jtagOtpAddr[otp_sec_pkg::ROW_AW-1:0];
				progData_reg <= jtagOtpWdata;
			end
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			rdPend_reg   <= 1'b0;
			readData_reg <= '0;
			blocked_reg  <= 1'b0;
		end
		else
		begin
			rdPend_reg <= apbOp && pwdata[otp_sec_pkg::CTL_READ];
			if (rdPend_reg)
				readData_reg <= sramWrData;
			// a refusal in the clearing cycle stays visible
			if (apbProgBlk || jtagProgBlk)
				blocked_reg <= 1'b1;
			else if (ctrlWrite && pwdata[otp_sec_pkg::CTL_CLRBLK])
				blocked_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			jtagOtpAck     <= 1'b0;
			jtagOtpDenied  <= 1'b0;
			jtagOtpRdata   <= '0;
			jtagRdPend_reg <= 1'b0;
		end
		else
		begin
			jtagOtpAck     <= 1'b0;
			jtagOtpDenied  <= 1'b0;
			jtagRdPend_reg <= 1'b0;
			if (jtagRdPend_reg)
			begin
				jtagOtpAck   <= 1'b1;
				jtagOtpRdata <= sramWrData;
			end
			else if (jtagIssue)
			begin
				if (jtagBlocked)
				begin
					jtagOtpAck    <= 1'b1;
					jtagOtpDenied <= 1'b1;
					jtagOtpRdata  <= '0;
				end
				else if (jtagOtpWrite)
					jtagOtpAck <= 1'b1;
				else
					jtagRdPend_reg <= 1'b1;
			end
		end
	end

	//------------------------------------------------
	// apb register file
	//------------------------------------------------
	always_comb
	begin
		ctrlRd = '0;
		ctrlRd[otp_sec_pkg::CTL_BUSY]    = rdPend_reg || !running;
		ctrlRd[otp_sec_pkg::CTL_BLOCKED] = blocked_reg;
		mapped = 1'b1;
		case (paddr)
			otp_sec_pkg::OFS_ADDR:   rdMux = {16'h0000, otpAddr_reg};
			otp_sec_pkg::OFS_DATA:   rdMux = otpData_reg;
			otp_sec_pkg::OFS_CTRL:   rdMux = ctrlRd;
			otp_sec_pkg::OFS_SEC:    rdMux = secReg_reg;
			otp_sec_pkg::OFS_RDATA:  rdMux = readData_reg;
			otp_sec_pkg::OFS_ID_ADR:
				rdMux = {8'h00, otp_sec_pkg::ADDR_PORT_ID};
			otp_sec_pkg::OFS_ID_DAT:
				rdMux = {8'h00, otp_sec_pkg::DATA_PORT_ID};
			otp_sec_pkg::OFS_ID_CTL:
				rdMux = {8'h00, otp_sec_pkg::CTRL_PORT_ID};
			default:
			begin
				rdMux  = '0;
				mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			prdata      <= '0;
			otpAddr_reg <= '0;
			otpData_reg <= '0;
		end
		else
		begin
			pready <= apbFirst;
			if (apbFirst)
			begin
				prdata  <= pwrite ? 32'h0000_0000 : rdMux;
				pslverr <= !mapped;
			end
			if (apbWrite && regHit(paddr, otp_sec_pkg::OFS_ADDR))
				otpAddr_reg <= pwdata[otp_sec_pkg::PORT_W-1:0];
			if (apbWrite && regHit(paddr, otp_sec_pkg::OFS_DATA))
				otpData_reg <= pwdata;
		end
	end

	//------------------------------------------------
	// checks
	//------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence sCopyStart;
		$rose(state_reg == otp_sec_pkg::ST_COPY);
	endsequence
	sequence sFirstWrite;
		sramWrValid && (sramWrAddr == otp_sec_pkg::BOOT_ROW);
	endsequence
	sequence sJtagLocked;
		jtagIssue && jtagBlocked;
	endsequence

	a_jtag_tap_off: assert property (
		secLoaded && secReg_reg[otp_sec_pkg::SEC_JTAG_OFF]
		|=> !jtagTapEnable)
		else $error("jtag tap enabled while disabled");
	a_link_gate: assert property (
		coreRelease |-> linkAccessEnable
		== !secReg_reg[otp_sec_pkg::SEC_LINK_OFF])
		else $error("link access does not follow security bit");
	a_secure_boot: assert property (
		coreRelease |-> bootFromOtp == secReg_reg[otp_sec_pkg::SEC_BOOT])
		else $error("boot source does not follow security bit");
	a_redundant_rows: assert property (
		$rose(coreRelease) |->
		redundantRowsEn == secReg_reg[otp_sec_pkg::SEC_REDUN])
		else $error("redundant rows do not follow security bit");
	a_sector_lock: assert property (
		progEn_reg && !progSec_reg |->
		!lockVec[progAddr_reg[otp_sec_pkg::ROW_AW-1 -:
		otp_sec_pkg::SECT_AW]])
		else $error("locked sector programmed");
	a_master_lock: assert property (
		progEn_reg |-> !secReg_reg[otp_sec_pkg::SEC_MASTER])
		else $error("programming under master lock");
	a_jtag_otp_deny: assert property (
		sJtagLocked |=> jtagOtpAck && jtagOtpDenied && !progEn_reg)
		else $error("blocked jtag access not refused");
	a_debug_pin_off: assert property (
		secLoaded && secReg_reg[otp_sec_pkg::SEC_DEBUG]
		|=> debugPinOeN && !debugRequest)
		else $error("debug pin active while disabled");
	a_user_ident: assert property (
		coreRelease |-> userIdentExtension
		== secReg_reg[otp_sec_pkg::SEC_UID_HI:otp_sec_pkg::SEC_UID_LO])
		else $error("user id extension mismatch");
	a_load_first: assert property (
		!secLoaded |=> !jtagTapEnable && !coreRelease && !sramWrValid)
		else $error("protection live before security load");
	a_copy_order: assert property (
		sCopyStart |=> sFirstWrite)
		else $error("boot copy does not start at row 0");
	a_reserved_zero: assert property (
		(secReg_reg & ~otp_sec_pkg::SEC_VALID_MASK) == '0)
		else $error("reserved security bits set");

endmodule : otp_security_control
`default_nettype wire

// File: bench/jtag_partner.sv
// partner model: jtag otp requester and pulled-up debug pin
`timescale 1ns/1ps
`default_nettype none
module jtag_partner
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// bench control
	input  wire logic        start,
	input  wire logic        wr,
	input  wire logic [15:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        pinLow,
	output var  logic [7:0]  answers,
	output var  logic        gotDenied,
	output var  logic [31:0] gotData,
	// jtag otp side
	output var  logic        jtagOtpReq,
	output var  logic        jtagOtpWrite,
	output var  logic [15:0] jtagOtpAddr,
	output var  logic [31:0] jtagOtpWdata,
	input  wire logic        jtagOtpAck,
	input  wire logic        jtagOtpDenied,
	input  wire logic [31:0] jtagOtpRdata,
	// debug pin
	input  wire logic        debugPinOeN,
	output var  logic        debugPinIn
);
	// open-drain line with pull-up: low if either side pulls
	always_comb
		debugPinIn = debugPinOeN & ~pinLow;

	always_ff @(posedge ref_clk)
		if (rst)
		begin
			jtagOtpReq   <= 1'b0;
			jtagOtpWrite <= 1'b0;
			jtagOtpAddr  <= 16'h0000;
			jtagOtpWdata <= 32'h0000_0000;
			answers      <= 8'h00;
		end
		else if (jtagOtpReq && jtagOtpAck)
		begin
			// released address and data stop showing the last request
			jtagOtpReq   <= 1'b0;
			jtagOtpAddr  <= ~jtagOtpAddr;
			jtagOtpWdata <= ~jtagOtpWdata;
			answers      <= answers + 8'h01;
			gotDenied    <= jtagOtpDenied;
			gotData      <= jtagOtpRdata;
		end
		else if (start && !jtagOtpReq)
		begin
			jtagOtpReq   <= 1'b1;
			jtagOtpWrite <= wr;
			jtagOtpAddr  <= addr;
			jtagOtpWdata <= wdata;
		end
endmodule : jtag_partner
`default_nettype wire

// File: bench/tb.sv
// testbench: apb programming, protection gates, jtag and debug pin
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic        jtagOtpReq, jtagOtpWrite, jtagOtpAck, jtagOtpDenied;
	logic        jtagTapEnable, linkAccessEnable, redundantRowsEn;
	logic        debugPinIn, debugBreak, debugPinOeN, debugRequest;
	logic        sramWrValid, bootFromOtp, coreRelease, slvErr, debugPinOut;
	logic        jStart, jWr, pinLow, gotDenied;
	logic [7:0]  paddr, answers;
	logic [9:0]  userIdentExtension;
	logic [15:0] jtagOtpAddr, jAddr;
	logic [31:0] pwdata, prdata, jtagOtpWdata, jtagOtpRdata;
	logic [31:0] jData, gotData, st, rd, sramWrData, row5Copy;
	logic [10:0] sramWrAddr;
	logic [31:0] ids [3] = '{32'h0010_0200, 32'h0020_0100, 32'h0010_0300};
	int          n_errors, checks, cycles, nRows;

	otp_security_control uut (.ref_clk, .rst, .paddr, .psel, .penable,
		.pwrite, .pwdata, .prdata, .pready, .pslverr, .jtagOtpReq,
		.jtagOtpWrite, .jtagOtpAddr, .jtagOtpWdata, .jtagOtpAck,
		.jtagOtpDenied, .jtagOtpRdata, .jtagTapEnable, .linkAccessEnable,
		.redundantRowsEn, .userIdentExtension, .debugPinIn, .debugBreak,
		.debugPinOut, .debugPinOeN, .debugRequest, .sramWrValid,
		.sramWrAddr, .sramWrData, .bootFromOtp, .coreRelease);

	jtag_partner partner (.ref_clk, .rst, .start(jStart), .wr(jWr),
		.addr(jAddr), .wdata(jData), .pinLow, .answers, .gotDenied,
		.gotData, .jtagOtpReq, .jtagOtpWrite, .jtagOtpAddr, .jtagOtpWdata,
		.jtagOtpAck, .jtagOtpDenied, .jtagOtpRdata, .debugPinOeN,
		.debugPinIn);

	initial
	begin
		ref_clk = 1'b0;
		forever
			#10 ref_clk = ~ref_clk;
	end

	//------------------------------------------------
	// shared tasks
	//------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge ref_clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rdv     = prdata;
		slvErr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// busy stays set for the whole boot copy, so polling covers it
	task automatic poll;
		st = 32'h0000_0100;
		while (st[8] !== 1'b0)
			apb(1'b0, otp_sec_pkg::OFS_CTRL, 32'h0, st);
	endtask : poll

	task automatic reboot;
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		nRows = 0;
		rst <= 1'b0;
		poll();
		chk("rows", nRows, 2048);
		chk("release", coreRelease, 1);
		apb(1'b0, otp_sec_pkg::OFS_SEC, 32'h0, rd);
	endtask : reboot

	task automatic op(input logic [15:0] a, input logic [31:0] d, cmd);
		apb(1'b1, otp_sec_pkg::OFS_ADDR, {16'h0000, a}, rd);
		apb(1'b1, otp_sec_pkg::OFS_DATA, d, rd);
		apb(1'b1, otp_sec_pkg::OFS_CTRL, cmd, rd);
		poll();
		apb(1'b1, otp_sec_pkg::OFS_CTRL, 32'h0000_0008, rd);
		apb(1'b1, otp_sec_pkg::OFS_CTRL, 32'h0000_0002, rd);
		apb(1'b0, otp_sec_pkg::OFS_RDATA, 32'h0, rd);
	endtask : op

	task automatic jt(input logic w, input logic [15:0] a);
		logic [7:0] n;
		begin
			n = answers;
			jWr    <= w;
			jAddr  <= a;
			jStart <= 1'b1;
			@(posedge ref_clk);
			jStart <= 1'b0;
			while (answers == n)
				@(posedge ref_clk);
			@(posedge ref_clk);
		end
	endtask : jt

	task automatic dbg(input logic [31:0] req, oeN);
		pinLow <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk("dbgreq", debugRequest, req);
		pinLow     <= 1'b0;
		debugBreak <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("dbgoe", debugPinOeN, oeN);
		chk("dbgout", debugPinOut, 0);
		debugBreak <= 1'b0;
	endtask : dbg

	always @(posedge ref_clk)
	begin
		cycles++;
		if (sramWrValid === 1'b1)
		begin
			chk("sramaddr", 32'(sramWrAddr), 32'(nRows));
			if (sramWrAddr === 11'h005)
				row5Copy = sramWrData;
			nRows++;
		end
		if (cycles == 20000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	//------------------------------------------------
	// scenarios
	//------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, debugBreak, jStart, jWr, pinLow} = '0;
		{paddr, pwdata, jAddr, jData} = '0;
		reboot();
		chk("sec", rd, 0);
		chk("tap", jtagTapEnable, 1);
		chk("link", linkAccessEnable, 1);
		chk("boot", bootFromOtp, 0);
		chk("redun", redundantRowsEn, 0);
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b0, 8'h14 + 8'(4 * i), 32'h0, rd);
			chk("portid", rd, ids[i]);
		end
		apb(1'b0, 8'h40, 32'h0, rd);
		chk("slverr", slvErr, 1);
		op(16'h0005, 32'hA5A5_0001, 32'h0000_0001);
		chk("row5", rd, 32'hA5A5_0001);
		op(16'h07FF, 32'h0000_0010, 32'h0000_0001);
		chk("lastrow", rd, 32'h0000_0010);
		op(16'h0800, 32'h0000_0001, 32'h0000_0001);
		chk("beyond", st[9], 1);
		jt(1'b0, 16'h0005);
		chk("jrd", gotData, 32'hA5A5_0001);
		chk("jrdok", gotDenied, 0);
		jData <= 32'h0000_3C00;
		jt(1'b1, 16'h0006);
		op(16'h0006, 32'h0, 32'h0000_0002);
		chk("jwr", rd, 32'h0000_3C00);
		dbg(1, 0);
		op(16'h0000, 32'h5540_E1FE, 32'h0000_0005);
		reboot();
		chk("sec2", rd, 32'h5540_E1A2);
		chk("copy5", row5Copy, 32'hA5A5_0001);
		chk("link2", linkAccessEnable, 0);
		chk("boot2", bootFromOtp, 1);
		chk("redun2", redundantRowsEn, 1);
		chk("uid", userIdentExtension, 32'h155);
		op(16'h0005, 32'h0000_0F00, 32'h0000_0001);
		chk("lock0", st[9], 1);
		chk("row5kept", rd, 32'hA5A5_0001);
		op(16'h0258, 32'h0000_0003, 32'h0000_0001);
		chk("sect1", rd, 32'h0000_0003);
		jt(1'b0, 16'h0005);
		chk("jdeny", gotDenied, 1);
		chk("jdenydata", gotData, 32'h0);
		dbg(0, 1);
		op(16'h0000, 32'h0000_1001, 32'h0000_0005);
		reboot();
		chk("sec3", rd, 32'h5540_F1A3);
		chk("tap3", jtagTapEnable, 0);
		op(16'h0259, 32'h0000_0004, 32'h0000_0001);
		chk("master", st[9], 1);
		chk("rowkept", rd, 32'h0);
		op(16'h0000, 32'h0000_0002, 32'h0000_0005);
		chk("secmaster", st[9], 1);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
